// file: core/ife_consts.svh
/*
 Constants of the instruction field extractor: field bounds in
 msb-first bit numbering, register offsets, reset values and the
 bits of the execute register.
 Assumes inclusion by bare name; definitions only.
*/
`ifndef IFE_CONSTS_SVH
`define IFE_CONSTS_SVH

// ------------------------------------------------------------
// field bounds, bit 0 is the word's most significant bit
// ------------------------------------------------------------
`define IFE_PRIMARY_OPCODE_FIRST 0
`define IFE_PRIMARY_OPCODE_LAST 5
`define IFE_HI5_FIRST 6
`define IFE_HI5_LAST 10
`define IFE_COND_FIELD_DEST_FIRST 6
`define IFE_COND_FIELD_DEST_LAST 8
`define IFE_MID5_FIRST 11
`define IFE_MID5_LAST 15
`define IFE_COND_FIELD_SRC_FIRST 11
`define IFE_COND_FIELD_SRC_LAST 13
`define IFE_CRM_FIRST 12
`define IFE_CRM_LAST 19
`define IFE_LO5_FIRST 16
`define IFE_LO5_LAST 20
`define IFE_SPLIT_FIRST 11
`define IFE_SPLIT_LAST 20
`define IFE_HALF_FIRST 16
`define IFE_HALF_LAST 31
`define IFE_EE_POS 16
`define IFE_LI_FIRST 6
`define IFE_LI_LAST 29
`define IFE_MB_FIRST 21
`define IFE_MB_LAST 25
`define IFE_ME_FIRST 26
`define IFE_ME_LAST 30
`define IFE_OE_POS 21
`define IFE_XO10_FIRST 21
`define IFE_XO9_FIRST 22
`define IFE_XO_LAST 30
`define IFE_LK_POS 31
`define IFE_RC_POS 31
`define IFE_LI_SHIFT 2

// ------------------------------------------------------------
// register byte offsets on the apb bus
// ------------------------------------------------------------
`define IFE_OFF_INSTR 8'h00
`define IFE_OFF_CIA 8'h04
`define IFE_OFF_EXEC 8'h08
`define IFE_OFF_LINK 8'h0C
`define IFE_OFF_CR 8'h10
`define IFE_OFF_XER 8'h14
`define IFE_OFF_GPR 8'h18
`define IFE_OFF_CRSEL 8'h1C
`define IFE_OFF_SIGNED_IMMEDIATE 8'h20
`define IFE_OFF_UNSIGNED_IMMEDIATE 8'h24
`define IFE_OFF_DISP 8'h28
`define IFE_OFF_BRANCH 8'h2C
`define IFE_OFF_ROT 8'h30
`define IFE_OFF_SPLIT 8'h34
`define IFE_OFF_OPC 8'h38

// ------------------------------------------------------------
// reset values and execute register bits
// ------------------------------------------------------------
`define IFE_RST_WORD 32'h0000_0000
`define IFE_INSTR_STEP 32'h0000_0004
`define IFE_EXEC_OVF_BIT 0
`define IFE_EXEC_CR_LO 4
`define IFE_EXEC_CR_HI 7

`endif

// file: core/ife_pkg.sv
/*
 Types and the shared extraction function of the field extractor.
 Assumes the surrounding code numbers instruction bits msb first.
*/
package ife_pkg;

   // ---------------------------------------------------------
   // state of the apb side
   // ---------------------------------------------------------
   typedef struct packed {
      logic [31:0] instr;
      logic [31:0] cia;
      logic [31:0] link;
      logic [31:0] cr;
      logic ov;
      logic so;
      logic [31:0] rdata;
      logic err;
   } ife_state_t;

   // field first..last, msb-first numbering, right aligned
   function automatic logic [31:0] ife_get(input logic [31:0] w, input int first, input int last);
      logic [31:0] mask;
      mask = (32'h0000_0001 << (last - first + 1)) - 32'h0000_0001;
      ife_get = (w >> (31 - last)) & mask;
   endfunction

endpackage

// file: core/ife_split_swap.sv
/*
 Forms a register number from a ten-bit split field.
 Assumes the field arrives right aligned, first half in the top bits.
*/
`timescale 1ns/10ps
module ife_split_swap
   import ife_pkg::*;
(
   input wire logic [9:0] split_field,
   output logic [9:0] reg_number
);

   // swap the two five-bit halves
   assign reg_number = {split_field[4:0], split_field[9:5]};

endmodule

// file: core/ife_sext.sv
/*
 Sign-extends a signed field to 32 bits, optionally appending zeros.
 Assumes IN_W + SHIFT stays below 32.
*/
`timescale 1ns/10ps
module ife_sext
   import ife_pkg::*;
#(
   parameter int IN_W = 16,
   parameter int SHIFT = 0
)
(
   input wire logic [IN_W-1:0] field,
   output logic [31:0] value
);

   // ---------------------------------------------------------
   // extension
   // ---------------------------------------------------------
   generate
      if (SHIFT == 0)
      begin : g_plain
         assign value = {{(32 - IN_W){field[IN_W-1]}}, field};
      end
      else
      begin : g_shift
         assign value = {{(32 - IN_W - SHIFT){field[IN_W-1]}}, field, {SHIFT{1'b0}}};
      end
   endgenerate

endmodule

// file: core/ife_top.sv
/*
 Instruction field extractor with an apb register window.
 Software loads an instruction word and its address, reads the split
 fields back, and commits the word through the execute register,
 which updates link, condition and exception state.
 Assumes a single 50 MHz pclk and an apb master that keeps psel,
 paddr, pwrite and pwdata steady through the access phase.
*/
`timescale 1ns/10ps
`include "ife_consts.svh"

module ife_top
   import ife_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [5:0] primary_opcode,
   output logic [9:0] extended_opcode,
   output logic [8:0] extended_opcode_oe,
   output logic [4:0] first_gpr_operand,
   output logic [4:0] second_gpr_operand,
   output logic [4:0] gpr_target_field,
   output logic [4:0] gpr_store_source_field,
   output logic [4:0] cond_bit_src_b,
   output logic [4:0] cond_bit_dest,
   output logic [2:0] cond_field_dest,
   output logic [2:0] cond_field_src,
   output logic [7:0] cond_field_mask,
   output logic [31:0] load_store_disp,
   output logic [31:0] signed_immediate,
   output logic [31:0] unsigned_immediate,
   output logic [31:0] long_branch_offset,
   output logic [4:0] mask_start_field,
   output logic [4:0] mask_stop_field,
   output logic [4:0] string_byte_count,
   output logic [4:0] trap_condition_field,
   output logic [9:0] special_reg_number,
   output logic [9:0] device_ctl_reg_number,
   output logic [9:0] timebase_number,
   output logic external_interrupt_enable,
   output logic link_update_bit,
   output logic record_bit,
   output logic overflow_enable_bit,
   output logic [31:0] link_register,
   output logic [31:0] cond_register,
   output logic arith_excess_flag,
   output logic summary_overflow_flag
);

   ife_state_t state_reg;
   ife_state_t state_next;
   logic [31:0] w;
   logic [9:0] spr_split;
   logic [9:0] dcr_split;
   logic [9:0] tbr_split;
   logic [15:0] half_field;
   logic [23:0] li_field;
   logic setup_phase;
   logic wr_access;
   logic [ADDR_W-1:0] exec_addr;

   assign w = state_reg.instr;
   assign exec_addr = ADDR_W'(`IFE_OFF_EXEC);

   // ---------------------------------------------------------
   // plain field extraction, msb-first numbering
   // ---------------------------------------------------------
   assign primary_opcode = 6'(ife_get(w, `IFE_PRIMARY_OPCODE_FIRST, `IFE_PRIMARY_OPCODE_LAST));
   assign extended_opcode = 10'(ife_get(w, `IFE_XO10_FIRST, `IFE_XO_LAST));
   assign extended_opcode_oe = 9'(ife_get(w, `IFE_XO9_FIRST, `IFE_XO_LAST));
   assign first_gpr_operand = 5'(ife_get(w, `IFE_MID5_FIRST, `IFE_MID5_LAST));
   assign second_gpr_operand = 5'(ife_get(w, `IFE_LO5_FIRST, `IFE_LO5_LAST));
   assign gpr_target_field = 5'(ife_get(w, `IFE_HI5_FIRST, `IFE_HI5_LAST));
   assign gpr_store_source_field = 5'(ife_get(w, `IFE_HI5_FIRST, `IFE_HI5_LAST));
   assign cond_bit_src_b = 5'(ife_get(w, `IFE_LO5_FIRST, `IFE_LO5_LAST));
   assign cond_bit_dest = 5'(ife_get(w, `IFE_HI5_FIRST, `IFE_HI5_LAST));
   assign cond_field_dest = 3'(ife_get(w, `IFE_COND_FIELD_DEST_FIRST, `IFE_COND_FIELD_DEST_LAST));
   assign cond_field_src = 3'(ife_get(w, `IFE_COND_FIELD_SRC_FIRST, `IFE_COND_FIELD_SRC_LAST));
   assign cond_field_mask = 8'(ife_get(w, `IFE_CRM_FIRST, `IFE_CRM_LAST));
   assign mask_start_field = 5'(ife_get(w, `IFE_MB_FIRST, `IFE_MB_LAST));
   assign mask_stop_field = 5'(ife_get(w, `IFE_ME_FIRST, `IFE_ME_LAST));
   assign string_byte_count = 5'(ife_get(w, `IFE_LO5_FIRST, `IFE_LO5_LAST));
   assign trap_condition_field = 5'(ife_get(w, `IFE_HI5_FIRST, `IFE_HI5_LAST));
   assign external_interrupt_enable = w[31 - `IFE_EE_POS];
   assign link_update_bit = w[31 - `IFE_LK_POS];
   assign record_bit = w[31 - `IFE_RC_POS];
   assign overflow_enable_bit = w[31 - `IFE_OE_POS];

   // ---------------------------------------------------------
   // immediates and displacements
   // ---------------------------------------------------------
   assign half_field = 16'(ife_get(w, `IFE_HALF_FIRST, `IFE_HALF_LAST));
   assign li_field = 24'(ife_get(w, `IFE_LI_FIRST, `IFE_LI_LAST));
   assign unsigned_immediate = {16'h0000, half_field};

   ife_sext #(.IN_W(16), .SHIFT(0)) u_disp_ext
   (
      .field(half_field),
      .value(load_store_disp)
   );

   ife_sext #(.IN_W(16), .SHIFT(0)) u_signed_immediate_ext
   (
      .field(half_field),
      .value(signed_immediate)
   );

   ife_sext #(.IN_W(24), .SHIFT(`IFE_LI_SHIFT)) u_li_ext
   (
      .field(li_field),
      .value(long_branch_offset)
   );

   // ---------------------------------------------------------
   // split register numbers
   // ---------------------------------------------------------
   assign spr_split = 10'(ife_get(w, `IFE_SPLIT_FIRST, `IFE_SPLIT_LAST));
   assign dcr_split = 10'(ife_get(w, `IFE_SPLIT_FIRST, `IFE_SPLIT_LAST));
   assign tbr_split = 10'(ife_get(w, `IFE_SPLIT_FIRST, `IFE_SPLIT_LAST));

   ife_split_swap u_spr_swap
   (
      .split_field(spr_split),
      .reg_number(special_reg_number)
   );

   ife_split_swap u_dcr_swap
   (
      .split_field(dcr_split),
      .reg_number(device_ctl_reg_number)
   );

   ife_split_swap u_tbr_swap
   (
      .split_field(tbr_split),
      .reg_number(timebase_number)
   );

   // ---------------------------------------------------------
   // apb handshake and state outputs
   // ---------------------------------------------------------
   assign setup_phase = psel && !penable;
   assign wr_access = psel && penable && pwrite;
   assign pready = 1'b1;
   assign pslverr = psel && penable && state_reg.err;
   assign prdata = state_reg.rdata;
   assign link_register = state_reg.link;
   assign cond_register = state_reg.cr;
   assign arith_excess_flag = state_reg.ov;
   assign summary_overflow_flag = state_reg.so;

   // next state: register writes, execute commit, read capture
   always_comb
   begin
      state_next = state_reg;
      if (wr_access)
      begin
         case (paddr)
            ADDR_W'(`IFE_OFF_INSTR): state_next.instr = pwdata;
            ADDR_W'(`IFE_OFF_CIA): state_next.cia = pwdata;
            ADDR_W'(`IFE_OFF_EXEC):
            begin
               state_next.cia = state_reg.cia + `IFE_INSTR_STEP;
               if (link_update_bit)
               begin
                  state_next.link = state_reg.cia + `IFE_INSTR_STEP;
               end
               if (record_bit)
               begin
                  state_next.cr[31:28] = pwdata[`IFE_EXEC_CR_HI:`IFE_EXEC_CR_LO];
               end
               if (overflow_enable_bit)
               begin
                  state_next.ov = pwdata[`IFE_EXEC_OVF_BIT];
                  state_next.so = state_reg.so | pwdata[`IFE_EXEC_OVF_BIT];
               end
            end
            default: state_next.instr = state_reg.instr;
         endcase
      end
      if (setup_phase)
      begin
         state_next.err = 1'b0;
         case (paddr)
            ADDR_W'(`IFE_OFF_INSTR): state_next.rdata = state_reg.instr;
            ADDR_W'(`IFE_OFF_CIA): state_next.rdata = state_reg.cia;
            ADDR_W'(`IFE_OFF_EXEC): state_next.rdata = `IFE_RST_WORD;
            ADDR_W'(`IFE_OFF_LINK): state_next.rdata = state_reg.link;
            ADDR_W'(`IFE_OFF_CR): state_next.rdata = state_reg.cr;
            ADDR_W'(`IFE_OFF_XER): state_next.rdata = {state_reg.so, state_reg.ov, 30'h0000_0000};
            ADDR_W'(`IFE_OFF_GPR): state_next.rdata = {17'h0_0000, first_gpr_operand, second_gpr_operand,
                                                       gpr_target_field};
            ADDR_W'(`IFE_OFF_CRSEL): state_next.rdata = {8'h00, cond_bit_src_b, cond_bit_dest, cond_field_dest,
                                                         cond_field_src, cond_field_mask};
            ADDR_W'(`IFE_OFF_SIGNED_IMMEDIATE): state_next.rdata = signed_immediate;
            ADDR_W'(`IFE_OFF_UNSIGNED_IMMEDIATE): state_next.rdata = unsigned_immediate;
            ADDR_W'(`IFE_OFF_DISP): state_next.rdata = load_store_disp;
            ADDR_W'(`IFE_OFF_BRANCH): state_next.rdata = long_branch_offset;
            ADDR_W'(`IFE_OFF_ROT): state_next.rdata = {12'h000, mask_start_field, mask_stop_field,
                                                       string_byte_count, trap_condition_field};
            ADDR_W'(`IFE_OFF_SPLIT): state_next.rdata = {2'b00, special_reg_number, device_ctl_reg_number,
                                                         timebase_number};
            ADDR_W'(`IFE_OFF_OPC): state_next.rdata = {4'h0, external_interrupt_enable, link_update_bit,
                                                       overflow_enable_bit, primary_opcode, extended_opcode,
                                                       extended_opcode_oe};
            default:
            begin
               state_next.rdata = `IFE_RST_WORD;
               state_next.err = 1'b1;
            end
         endcase
      end
   end

   // state register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // ---------------------------------------------------------
   // checks
   // ---------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   link_update_a: assert property ((wr_access && paddr == exec_addr && link_update_bit) |=>
      (link_register == $past(state_reg.cia) + `IFE_INSTR_STEP))
      else $error("link register not loaded with next address");

   link_hold_a: assert property ((wr_access && paddr == exec_addr && !link_update_bit) |=>
      $stable(link_register))
      else $error("link register changed without link bit");

   record_update_a: assert property ((wr_access && paddr == exec_addr && record_bit) |=>
      (cond_register[31:28] == $past(pwdata[7:4])))
      else $error("condition register not updated");

   record_hold_a: assert property ((wr_access && paddr == exec_addr && !record_bit) |=>
      $stable(cond_register))
      else $error("condition register changed without record bit");

   ovf_update_a: assert property ((wr_access && paddr == exec_addr && overflow_enable_bit && pwdata[0]) |=>
      (arith_excess_flag && summary_overflow_flag))
      else $error("overflow flags not set");

   ovf_hold_a: assert property ((wr_access && paddr == exec_addr && !overflow_enable_bit) |=>
      ($stable(arith_excess_flag) && $stable(summary_overflow_flag)))
      else $error("overflow flags changed without enable bit");

   opcode_field_a: assert property (primary_opcode == state_reg.instr[31:26])
      else $error("primary opcode misplaced");

   branch_ext_a: assert property (
      long_branch_offset == {{6{state_reg.instr[25]}}, state_reg.instr[25:2], 2'b00})
      else $error("branch offset wrong");

   split_swap_a: assert property (special_reg_number == {state_reg.instr[15:11], state_reg.instr[20:16]})
      else $error("split field not swapped");

   signed_immediate_ext_a: assert property ((signed_immediate[31:16] == {16{state_reg.instr[15]}})
      && (unsigned_immediate[31:16] == 16'h0000))
      else $error("immediate extension wrong");

   instr_load_a: assert property ((wr_access && paddr == ADDR_W'(`IFE_OFF_INSTR)) |=>
      (gpr_target_field == $past(pwdata[25:21])))
      else $error("target field not taken from loaded word");

   cia_step_a: assert property ((wr_access && paddr == exec_addr) |=>
      (state_reg.cia == $past(state_reg.cia) + `IFE_INSTR_STEP))
      else $error("instruction address not advanced");

   ovf_clear_a: assert property ((wr_access && paddr == exec_addr && overflow_enable_bit && !pwdata[0]) |=>
      (!arith_excess_flag && (summary_overflow_flag == $past(summary_overflow_flag))))
      else $error("overflow flag not cleared or summary lost");

   gpr_field_a: assert property ((first_gpr_operand == state_reg.instr[20:16])
      && (second_gpr_operand == state_reg.instr[15:11]))
      else $error("register operand fields misplaced");

   cond_field_a: assert property ((cond_field_dest == state_reg.instr[25:23])
      && (cond_field_src == state_reg.instr[20:18]))
      else $error("condition field selectors misplaced");

   ee_bit_a: assert property (external_interrupt_enable == state_reg.instr[15])
      else $error("interrupt enable bit misplaced");

   xo_field_a: assert property ((extended_opcode == state_reg.instr[10:1])
      && (extended_opcode_oe == state_reg.instr[9:1]))
      else $error("extended opcode misplaced");

   rot_field_a: assert property ((mask_start_field == state_reg.instr[10:6])
      && (mask_stop_field == state_reg.instr[5:1]))
      else $error("rotate mask bounds misplaced");

   dcr_swap_a: assert property (device_ctl_reg_number == {state_reg.instr[15:11], state_reg.instr[20:16]})
      else $error("device control number not swapped");

   tbr_swap_a: assert property (timebase_number == {state_reg.instr[15:11], state_reg.instr[20:16]})
      else $error("time base number not swapped");

endmodule

// file: tb/ife_fetch_model.sv
/*
 Fetch-side model: hands out instruction words from a small program.
 Assumes the bench picks a slot and reads the word combinationally.
*/
`timescale 1ns/10ps
module ife_fetch_model
(
   input wire logic [2:0] slot,
   output logic [31:0] word
);
   // ---------------------------------------------------------
   // program of edge patterns for the field extractor
   // ---------------------------------------------------------
   // word table, last three drive the commit checks
   always_comb
   begin
      case (slot)
         3'h0: word = 32'hFFFF_FFFF;
         3'h1: word = 32'h8000_0001;
         3'h2: word = 32'h1234_5678;
         3'h3: word = 32'hA5A5_5A5A;
         3'h4: word = 32'h0400_0002;
         3'h5: word = 32'h0000_0401;
         3'h6: word = 32'hFFFF_FBFE;
         default: word = 32'h0000_0400;
      endcase
   end
endmodule

// file: tb/ife_top_tb_top.sv
/*
 Self-checking bench of the field extractor, apb tasks and scenarios.
 Assumes ife_top answers with pready and the fetch model gives words.
*/
`timescale 1ns/10ps
`include "ife_consts.svh"
module ife_top_tb_top;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [2:0] slot;
   logic [31:0] pwdata, prdata, word, load_store_disp, signed_immediate, unsigned_immediate;
   logic [31:0] long_branch_offset, link_register, cond_register;
   logic external_interrupt_enable, link_update_bit, record_bit, overflow_enable_bit;
   logic arith_excess_flag, summary_overflow_flag;
   logic [5:0] primary_opcode;
   logic [9:0] extended_opcode, special_reg_number, device_ctl_reg_number, timebase_number;
   logic [8:0] extended_opcode_oe;
   logic [7:0] cond_field_mask;
   logic [2:0] cond_field_dest, cond_field_src;
   logic [4:0] first_gpr_operand, second_gpr_operand, gpr_target_field, gpr_store_source_field;
   logic [4:0] cond_bit_src_b, cond_bit_dest, mask_start_field, mask_stop_field;
   logic [4:0] string_byte_count, trap_condition_field;
   int bad_count, checked;

   // ---------------------------------------------------------
   // design and fetch model
   // ---------------------------------------------------------
   ife_top #(.ADDR_W(8)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .primary_opcode, .extended_opcode, .extended_opcode_oe,
      .first_gpr_operand, .second_gpr_operand, .gpr_target_field, .gpr_store_source_field,
      .cond_bit_src_b, .cond_bit_dest, .cond_field_dest, .cond_field_src, .cond_field_mask,
      .load_store_disp, .signed_immediate, .unsigned_immediate, .long_branch_offset,
      .mask_start_field, .mask_stop_field, .string_byte_count, .trap_condition_field,
      .special_reg_number, .device_ctl_reg_number, .timebase_number, .external_interrupt_enable,
      .link_update_bit, .record_bit, .overflow_enable_bit, .link_register, .cond_register,
      .arith_excess_flag, .summary_overflow_flag);
   ife_fetch_model u_fetch (.slot, .word);

   // clock of 20 ns
   initial
   begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   // ---------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------
   task automatic wrap_up();
      if (bad_count == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // field first..last counted from the msb, right aligned
   function automatic logic [31:0] fld(input logic [31:0] w, input int f, input int l);
      fld = 32'h0000_0000;
      for (int i = f; i <= l; i++)
         fld = {fld[30:0], w[31-i]};
   endfunction

   // one apb transfer, held until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic er);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1)
      begin
         bad_count++;
         wrap_up();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      logic e;
      apb(1'b1, a, d, x, e);
   endtask

   task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp, input logic xe);
      logic [31:0] x;
      logic e;
      apb(1'b0, a, 32'h0000_0000, x, e);
      check(what, x, exp);
      check("pslverr", {31'h0000_0000, e}, {31'h0000_0000, xe});
   endtask

   task automatic load(input logic [2:0] s, output logic [31:0] w);
      slot <= s;
      @(negedge pclk);
      w = word;
      wr(`IFE_OFF_INSTR, w);
      @(negedge pclk);
   endtask

   // ---------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------
   // everything cleared out of reset
   task automatic test_reset();
      @(negedge pclk);
      check("opcode", primary_opcode, 32'h0000_0000);
      check("link", link_register, 32'h0000_0000);
      check("cr", cond_register, 32'h0000_0000);
      rdchk("instr", `IFE_OFF_INSTR, 32'h0000_0000, 1'b0);
   endtask

   // every field against msb-first extraction of the word
   task automatic test_fields(input logic [2:0] s);
      logic [31:0] w, h, li, sp;
      load(s, w);
      h = fld(w, 16, 31);
      li = fld(w, 6, 29);
      sp = fld(w, 11, 20);
      check("opcode", primary_opcode, fld(w, 0, 5));
      check("xo10", extended_opcode, fld(w, 21, 30));
      check("xo9", extended_opcode_oe, fld(w, 22, 30));
      check("gpr a", first_gpr_operand, fld(w, 11, 15));
      check("gpr b", second_gpr_operand, fld(w, 16, 20));
      check("gpr t", gpr_target_field, fld(w, 6, 10));
      check("gpr s", gpr_store_source_field, fld(w, 6, 10));
      check("crb b", cond_bit_src_b, fld(w, 16, 20));
      check("crb d", cond_bit_dest, fld(w, 6, 10));
      check("crf d", cond_field_dest, fld(w, 6, 8));
      check("crf s", cond_field_src, fld(w, 11, 13));
      check("crm", cond_field_mask, fld(w, 12, 19));
      check("disp", load_store_disp, {{16{h[15]}}, h[15:0]});
      check("signed_immediate", signed_immediate, {{16{h[15]}}, h[15:0]});
      check("unsigned_immediate", unsigned_immediate, h);
      check("li", long_branch_offset, {{6{li[23]}}, li[23:0], 2'b00});
      check("mb", mask_start_field, fld(w, 21, 25));
      check("me", mask_stop_field, fld(w, 26, 30));
      check("nb", string_byte_count, fld(w, 16, 20));
      check("trap", trap_condition_field, fld(w, 6, 10));
      check("spr", special_reg_number, {sp[4:0], sp[9:5]});
      check("dcr", device_ctl_reg_number, {sp[4:0], sp[9:5]});
      check("tbr", timebase_number, {sp[4:0], sp[9:5]});
      check("ee", external_interrupt_enable, fld(w, 16, 16));
      check("lk", link_update_bit, fld(w, 31, 31));
      check("rc", record_bit, fld(w, 31, 31));
      check("oe", overflow_enable_bit, fld(w, 21, 21));
      // read-back windows of the same word
      rdchk("gpr rd", `IFE_OFF_GPR, {17'h0_0000, 5'(fld(w, 11, 15)), 5'(fld(w, 16, 20)),
         5'(fld(w, 6, 10))}, 1'b0);
      rdchk("split rd", `IFE_OFF_SPLIT, {2'b00, {3{sp[4:0], sp[9:5]}}}, 1'b0);
      rdchk("branch rd", `IFE_OFF_BRANCH, {{6{li[23]}}, li[23:0], 2'b00}, 1'b0);
      rdchk("opc rd", `IFE_OFF_OPC, {4'h0, 1'(fld(w, 16, 16)), 1'(fld(w, 31, 31)), 1'(fld(w, 21, 21)),
         6'(fld(w, 0, 5)), 10'(fld(w, 21, 30)), 9'(fld(w, 22, 30))}, 1'b0);
   endtask

   // commits with and without link, record and overflow bits
   task automatic test_commit();
      logic [31:0] w;
      wr(`IFE_OFF_CIA, 32'h0000_1000);
      load(3'h5, w);
      wr(`IFE_OFF_EXEC, 32'h0000_00A1);
      @(negedge pclk);
      check("link", link_register, 32'h0000_1004);
      check("cr", cond_register, 32'hA000_0000);
      check("ov", arith_excess_flag, 32'h0000_0001);
      check("so", summary_overflow_flag, 32'h0000_0001);
      load(3'h6, w);
      wr(`IFE_OFF_EXEC, 32'h0000_0050);
      @(negedge pclk);
      check("link", link_register, 32'h0000_1004);
      check("cr", cond_register, 32'hA000_0000);
      check("ov", arith_excess_flag, 32'h0000_0001);
      load(3'h7, w);
      wr(`IFE_OFF_EXEC, 32'h0000_0000);
      @(negedge pclk);
      check("ov", arith_excess_flag, 32'h0000_0000);
      check("so", summary_overflow_flag, 32'h0000_0001);
      check("link", link_register, 32'h0000_1004);
      rdchk("xer", `IFE_OFF_XER, 32'h8000_0000, 1'b0);
      rdchk("cr rd", `IFE_OFF_CR, 32'hA000_0000, 1'b0);
      rdchk("cia", `IFE_OFF_CIA, 32'h0000_100C, 1'b0);
   endtask

   // read-only, write-only and unmapped places
   task automatic test_bus();
      wr(`IFE_OFF_LINK, 32'hFFFF_FFFF);
      rdchk("link ro", `IFE_OFF_LINK, 32'h0000_1004, 1'b0);
      wr(8'h3C, 32'hFFFF_FFFF);
      rdchk("unmapped", 8'h3C, 32'h0000_0000, 1'b1);
      rdchk("exec", `IFE_OFF_EXEC, 32'h0000_0000, 1'b0);
      rdchk("instr", `IFE_OFF_INSTR, 32'h0000_0400, 1'b0);
   endtask

   // ---------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------
   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      slot = 3'h0;
      bad_count = 0;
      checked = 0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      test_reset();
      for (int i = 0; i < 5; i++)
         test_fields(i[2:0]);
      test_commit();
      test_bus();
      wrap_up();
   end
endmodule
